// ### verilog/ipw_ctrl.sv
// interrupt arbitration, entry sequencing and halt / wake-up control
`timescale 1ns/100ps
module ipw_ctrl (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire ipw_pkg::ipw_cpu_cmd_s cpu_cmd_in,
  input wire logic top_level_pin_interrupt_in,
  input wire logic top_level_pin_rising_in,
  input wire logic [ipw_pkg::NPIN-1:0] ext_pin_in,
  input wire ipw_pkg::ipw_ext_cfg_s external_irq_sensitivity_control_in,
  input wire logic [2*ipw_pkg::NMSK-1:0] software_priority_registers_in,
  input wire logic [ipw_pkg::NPER-1:0] periph_flag_in,
  input wire logic [ipw_pkg::NPER-1:0] periph_enable_in,
  input wire logic [ipw_pkg::NPER-1:0] periph_clear_seq_in,
  input wire logic timebase_irq_enable_in,
  input wire logic watchdog_enabled_in,
  input wire logic watchdog_in_stop_option_in,
  input wire logic startup_long_in,
  output logic push_req_out,
  output logic vector_load_out,
  output logic [ipw_pkg::SRC_W-1:0] vector_id_out,
  output logic mask_level_high_bit_out,
  output logic mask_level_low_bit_out,
  output logic osc_run_out,
  output logic periph_clk_en_out,
  output logic halted_out,
  output logic wdg_reset_out
);
  import ipw_pkg::*;

  ipw_state_e state_r;
  logic [1:0] mask_r;
  logic [SRC_W-1:0] sel_r;
  logic [CNT_W-1:0] cnt_r;
  logic rst_pend_r;
  logic tli_pend_r;
  logic trap_pend_r;
  logic [NEXT-1:0] ext_pend_r;
  logic [NPER-1:0] per_pend_r;

  logic tli_s1_r;
  logic tli_s2_r;
  logic tli_s3_r;
  logic [NPIN-1:0] ext_s1_r;
  logic [NPIN-1:0] ext_s2_r;
  logic [NPIN-1:0] ext_s3_r;

  logic tli_edge;
  logic [NEXT-1:0] ext_edge;
  logic [NEXT-1:0] ext_low;
  logic [NSRC-1:0] req;
  logic [NSRC-1:0] wake_cap;
  logic [2*NSRC-1:0] lvls;
  logic found;
  logic [SRC_W-1:0] win;
  logic [NSRC-1:0] served;
  logic enter_vec;
  logic do_pop;
  logic [1:0] stack_top;
  logic [CNT_W-1:0] start_last;

  // software level of every source, non-maskables pinned to the top
  function automatic logic [2*NSRC-1:0] src_levels(
      input logic [2*NMSK-1:0] sw);
    logic [2*NSRC-1:0] l;
    l = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (i <= NMI_LAST) begin
        l[2*i +: 2] = LEVEL_TOP; // RULE4
      end else begin
        l[2*i +: 2] = sw[2*(i-SRC_EXT0) +: 2];
      end
    end
    return l;
  endfunction

  // walk from lowest to highest hardware rank so the highest rank wins a tie
  function automatic logic [SRC_W:0] arbitrate(
      input logic [NSRC-1:0] r,
      input logic [2*NSRC-1:0] l,
      input logic [1:0] cur);
    logic hit;
    logic [SRC_W-1:0] idx;
    logic [1:0] best;
    logic ok;
    hit = 1'b0;
    idx = '0;
    best = '0;
    ok = 1'b0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      ok = r[i] && ((i <= NMI_LAST) || (l[2*i +: 2] > cur)); // RULE5 RULE9
      if (ok && (!hit || l[2*i +: 2] >= best)) begin // RULE1 RULE3
        hit = 1'b1;
        best = l[2*i +: 2];
        idx = SRC_W'(i);
      end
    end
    return {hit, idx};
  endfunction

  // edge seen on one synchronised pin under a group sensitivity code
  function automatic logic pin_edge(input logic [1:0] s, input logic cur,
      input logic prev);
    logic rise;
    logic fall;
    rise = cur && !prev;
    fall = !cur && prev;
    unique case (s)
      SENS_RISE: pin_edge = rise;
      SENS_FALL: pin_edge = fall;
      SENS_BOTH: pin_edge = rise || fall;
      SENS_LOW: pin_edge = 1'b0;
    endcase
  endfunction

  // pins are asynchronous: two stages before use, third for edge history
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tli_s1_r <= 1'b0;
      tli_s2_r <= 1'b0;
      tli_s3_r <= 1'b0;
    end else begin
      tli_s1_r <= top_level_pin_interrupt_in;
      tli_s2_r <= tli_s1_r;
      tli_s3_r <= tli_s2_r;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ext_s1_r <= '1;
      ext_s2_r <= '1;
      ext_s3_r <= '1;
    end else begin
      ext_s1_r <= ext_pin_in;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  assign tli_edge = top_level_pin_rising_in ?
      (tli_s2_r && !tli_s3_r) : (!tli_s2_r && tli_s3_r); // RULE10

  always_comb begin
    logic [1:0] s;
    s = '0;
    ext_edge = '0;
    ext_low = '0;
    for (int g = 0; g < NEXT; g++) begin
      s = external_irq_sensitivity_control_in.sens[2*g +: 2]; // RULE12
      for (int p = 0; p < PINS_PER_GRP; p++) begin
        if (external_irq_sensitivity_control_in.pin_sel[g*PINS_PER_GRP + p]) begin
          ext_edge[g] = ext_edge[g] || pin_edge(s,
              ext_s2_r[g*PINS_PER_GRP + p], ext_s3_r[g*PINS_PER_GRP + p]); // RULE14
          ext_low[g] = ext_low[g] ||
              (s == SENS_LOW && !ext_s2_r[g*PINS_PER_GRP + p]); // RULE14
        end
      end
    end
  end

  // request vector in hardware rank order, index 0 highest
  always_comb begin
    req = '0;
    req[SRC_RST] = 1'b0;
    req[SRC_TLI] = tli_pend_r;
    req[SRC_TRAP] = trap_pend_r;
    req[SRC_EXT0 +: NEXT] = ext_pend_r | ext_low;
    req[SRC_PER0 +: NPER] = per_pend_r & periph_flag_in & periph_enable_in; // RULE15
  end

  assign wake_cap = {PER_WAKE, {NEXT{1'b1}}, 3'h7};
  assign lvls = src_levels(software_priority_registers_in);
  assign {found, win} = arbitrate(req & wake_cap_mask(state_r), lvls,
      mask_to_level(mask_r));
  assign start_last = startup_long_in ? CNT_W'(STARTUP_LONG_CYC - 1)
      : CNT_W'(STARTUP_SHORT_CYC - 1); // RULE18
  assign enter_vec = (state_r == ST_VEC);
  assign do_pop = (state_r == ST_RUN) && cpu_cmd_in.iret;

  // only halt-capable sources count while stopped
  function automatic logic [NSRC-1:0] wake_cap_mask(input ipw_state_e st);
    wake_cap_mask = (st == ST_HALT) ? wake_cap : '1;
  endfunction

  always_comb begin
    served = '0;
    if (enter_vec) begin
      served[sel_r] = 1'b1;
    end
  end

  // pending latches: hardware set wins over service clear
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tli_pend_r <= 1'b0;
      trap_pend_r <= 1'b0;
    end else begin
      tli_pend_r <= (tli_pend_r && !served[SRC_TLI]) || tli_edge; // RULE2
      trap_pend_r <= (trap_pend_r && !served[SRC_TRAP]) || cpu_cmd_in.trap; // RULE7
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ext_pend_r <= '0;
    end else begin
      ext_pend_r <= (ext_pend_r & ~served[SRC_EXT0 +: NEXT]) | ext_edge; // RULE13
    end
  end

  // the clearing sequence wins: a request caught meanwhile is lost
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      per_pend_r <= '0;
    end else begin
      per_pend_r <= (per_pend_r | (periph_flag_in & periph_enable_in))
          & ~periph_clear_seq_in; // RULE16
    end
  end

  ipw_level_stack u_stack (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .push_in(enter_vec && sel_r != SRC_RST),
    .push_data_in(mask_r),
    .pop_in(do_pop),
    .top_out(stack_top)
  );

  // sequencing of entries, halt and wake-up
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r <= ST_WAKE;
      sel_r <= SRC_RST;
      rst_pend_r <= 1'b1;
    end else begin
      unique case (state_r)
        ST_RUN: begin
          if (cpu_cmd_in.halt) begin
            if (!(watchdog_enabled_in && watchdog_in_stop_option_in)
                && !timebase_irq_enable_in) begin
              state_r <= ST_HALT; // RULE17
            end
          end else if (cpu_cmd_in.boundary && found) begin
            sel_r <= win;
            state_r <= ST_PUSH; // RULE6
          end
        end
        ST_PUSH: begin
          if (cpu_cmd_in.push_done) begin
            state_r <= ST_VEC;
          end
        end
        ST_VEC: begin
          rst_pend_r <= 1'b0;
          state_r <= ST_RUN;
        end
        ST_HALT: begin
          if (found) begin
            state_r <= ST_WAKE; // RULE19
          end
        end
        ST_WAKE: begin
          if (cnt_r == start_last) begin
            state_r <= rst_pend_r ? ST_VEC : ST_RUN; // RULE8
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_r <= '0;
    end else if (state_r == ST_WAKE) begin
      cnt_r <= cnt_r + 12'h001; // RULE18
    end else begin
      cnt_r <= '0;
    end
  end

  // mask bits: reset and non-maskables give level 3, halt forces 10b
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mask_r <= MASK_TOP; // RULE8
    end else if (state_r == ST_RUN && cpu_cmd_in.halt
        && !(watchdog_enabled_in && watchdog_in_stop_option_in)
        && !timebase_irq_enable_in) begin
      mask_r <= MASK_HALT; // RULE19
    end else if (enter_vec) begin
      mask_r <= level_to_mask(lvls[2*sel_r +: 2]); // RULE6 RULE22
    end else if (do_pop) begin
      mask_r <= stack_top; // RULE22
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mask_level_high_bit_out <= MASK_TOP[1];
      mask_level_low_bit_out <= MASK_TOP[0];
    end else begin
      mask_level_high_bit_out <= mask_r[1];
      mask_level_low_bit_out <= mask_r[0];
    end
  end

  // stacking request held until the core reports the push finished
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      push_req_out <= 1'b0;
    end else if (state_r == ST_RUN && !cpu_cmd_in.halt
        && cpu_cmd_in.boundary && found) begin
      push_req_out <= 1'b1; // RULE6 RULE22
    end else if (state_r == ST_PUSH && cpu_cmd_in.push_done) begin
      push_req_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      vector_load_out <= 1'b0;
      vector_id_out <= SRC_RST;
    end else begin
      vector_load_out <= enter_vec;
      if (enter_vec) begin
        vector_id_out <= sel_r;
      end
    end
  end

  // oscillator off only while halted; peripheral clocks also off during wake-up start-up
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      osc_run_out <= 1'b1;
      periph_clk_en_out <= 1'b0;
      halted_out <= 1'b0;
    end else begin
      osc_run_out <= (state_r != ST_HALT) || found; // RULE18 RULE20
      periph_clk_en_out <= (state_r == ST_RUN) || (state_r == ST_PUSH)
          || (state_r == ST_VEC); // RULE20
      halted_out <= (state_r == ST_HALT) && !found;
    end
  end

  // halt with an armed watchdog and the option bit set resets instead
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wdg_reset_out <= 1'b0;
    end else begin
      wdg_reset_out <= (state_r == ST_RUN) && cpu_cmd_in.halt
          && watchdog_enabled_in && watchdog_in_stop_option_in; // RULE21
    end
  end
endmodule

// ### verilog/ipw_pkg.sv
// constants, types and helpers of the interrupt priority and halt wake-up block
// What the document requires
// RULE1: serve highest software priority first; ties go to highest hardware priority
// RULE2: unserved requests stay latched until they win arbitration
// RULE3: every source has a unique hardware rank; software levels may repeat
// RULE4: top-level pin, reset and trap arbitrate at the top software level
// RULE5: non-maskable sources ignore mask bits and wake from halt
// RULE6: non-maskable entry stacks state, loads vector, sets mask to level 3
// RULE7: trap instruction raises non-maskable entry; top-level pin may preempt it
// RULE8: reset outranks all; code after reset runs at level 3
// RULE9: maskable source served only if enabled and above current level
// RULE10: chosen edge on top-level pin raises it; served like trap
// RULE11: software never issues trap inside the top-level pin routine
// RULE12: external pins wake from halt; sensitivity chosen by control bits
// RULE13: edge-triggered external requests latch and clear on routine entry
// RULE14: selected pins of one group are ORed into one line
// RULE15: peripheral request only while its flag and enable are both set
// RULE16: clearing sequence drops the peripheral latch, losing any pending request
// RULE17: halt entered by halt instruction while time-base enable is clear
// RULE18: on wake or reset, oscillator restarts and waits 256 or 4096 cycles
// RULE19: entering halt forces mask bits to 10b; pending request wakes at once
// RULE20: in halt, oscillator and internal and peripheral clocks stop
// RULE21: halt with watchdog enabled gives watchdog reset per option bit
// RULE22: entry stacks mask bits, sets routine level, restores them on return
package ipw_pkg;
  localparam int NSRC = 9;
  localparam int SRC_W = 4;
  localparam int NEXT = 2;
  localparam int NPIN = 8;
  localparam int PINS_PER_GRP = 4;
  localparam int NPER = 4;
  localparam int NMSK = 6;
  localparam logic [SRC_W-1:0] SRC_RST = 4'h0;
  localparam logic [SRC_W-1:0] SRC_TLI = 4'h1;
  localparam logic [SRC_W-1:0] SRC_TRAP = 4'h2;
  localparam int SRC_EXT0 = 3;
  localparam int SRC_PER0 = 5;
  localparam int NMI_LAST = 2;
  // mask bit codes: 10b level 0, 01b level 1, 00b level 2, 11b level 3
  localparam logic [1:0] MASK_HALT = 2'h2;
  localparam logic [1:0] MASK_TOP = 2'h3;
  localparam logic [1:0] LEVEL_TOP = 2'h3;
  // group sensitivity codes
  localparam logic [1:0] SENS_LOW = 2'h0;
  localparam logic [1:0] SENS_RISE = 2'h1;
  localparam logic [1:0] SENS_FALL = 2'h2;
  localparam logic [1:0] SENS_BOTH = 2'h3;
  // peripherals allowed to leave halt; peripheral 0 is a time base
  localparam logic [NPER-1:0] PER_WAKE = 4'he;
  localparam int STARTUP_SHORT_CYC = 256;
  localparam int STARTUP_LONG_CYC = 4096;
  localparam int CNT_W = 12;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 4;

  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_PUSH = 5'h02,
    ST_VEC = 5'h04,
    ST_HALT = 5'h08,
    ST_WAKE = 5'h10
  } ipw_state_e;

  typedef struct packed {
    logic boundary;
    logic trap;
    logic halt;
    logic iret;
    logic push_done;
  } ipw_cpu_cmd_s;

  typedef struct packed {
    logic [NPIN-1:0] pin_sel;
    logic [2*NEXT-1:0] sens;
  } ipw_ext_cfg_s;

  // code and level are two minus each other, modulo four, so both maps are the same
  function automatic logic [1:0] mask_to_level(input logic [1:0] m);
    mask_to_level = 2'h2 - m;
  endfunction

  function automatic logic [1:0] level_to_mask(input logic [1:0] l);
    level_to_mask = 2'h2 - l;
  endfunction
endpackage

// ### verilog/ipw_level_stack.sv
// small stack of saved mask bits for nested interrupt routines
`timescale 1ns/100ps
module ipw_level_stack (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic push_in,
  input wire logic [1:0] push_data_in,
  input wire logic pop_in,
  output logic [1:0] top_out
);
  import ipw_pkg::*;
  logic [1:0] mem [STACK_DEPTH];
  logic [SP_W-1:0] sp_r;

  // no overflow guard: nesting is bounded by four software levels
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sp_r <= '0;
    end else if (push_in) begin
      sp_r <= sp_r + 4'h1;
    end else if (pop_in && sp_r != '0) begin
      sp_r <= sp_r - 4'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push_in) begin
      mem[sp_r[SP_W-2:0]] <= push_data_in;
    end
  end

  // read data come from a register holding the current top entry
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      top_out <= MASK_TOP;
    end else if (push_in) begin
      top_out <= push_data_in;
    end else if (pop_in && sp_r > 4'h1) begin
      top_out <= mem[3'(sp_r - 4'h2)];
    end
  end
endmodule

// ### tb/ipw_checker.sv
// concurrent checks on the ports of the interrupt controller
`timescale 1ns/100ps
module ipw_checker (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire ipw_pkg::ipw_cpu_cmd_s cpu_cmd_in,
  input wire logic [2*ipw_pkg::NMSK-1:0] software_priority_registers_in,
  input wire logic timebase_irq_enable_in,
  input wire logic watchdog_enabled_in,
  input wire logic watchdog_in_stop_option_in,
  input wire logic push_req_out,
  input wire logic vector_load_out,
  input wire logic [ipw_pkg::SRC_W-1:0] vector_id_out,
  input wire logic mask_level_high_bit_out,
  input wire logic mask_level_low_bit_out,
  input wire logic osc_run_out,
  input wire logic periph_clk_en_out,
  input wire logic halted_out,
  input wire logic wdg_reset_out
);
  import ipw_pkg::*;
  logic [1:0] mask;
  logic [3:0] idx;
  logic [1:0] ent_mask;
  logic halt_ok;
  logic [12:0] up_cnt;
  assign mask = {mask_level_high_bit_out, mask_level_low_bit_out};
  assign idx = vector_id_out - 4'h3;
  // mask code is two minus the level, modulo four
  assign ent_mask = 2'h2 - software_priority_registers_in[2*idx +: 2];
  // only a halt taken in plain running state is judged
  assign halt_ok = cpu_cmd_in.halt && !timebase_irq_enable_in && !watchdog_enabled_in &&
    !push_req_out && !vector_load_out && !halted_out && periph_clk_en_out;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      up_cnt <= 13'h0;
    end else if (!osc_run_out) begin
      up_cnt <= 13'h0;
    end else if (up_cnt != 13'h1fff) begin
      up_cnt <= up_cnt + 13'h1;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  push_to_vec_a: assert property (push_req_out && cpu_cmd_in.push_done |-> ##2 vector_load_out)
    else $error("vector load late after stacking");
  push_hold_a: assert property ($fell(push_req_out) |-> $past(cpu_cmd_in.push_done))
    else $error("stack request dropped without done");
  nmi_mask_a: assert property (vector_load_out && vector_id_out <= SRC_TRAP |=> mask == MASK_TOP)
    else $error("mask not top after non-maskable entry");
  entry_level_a: assert property (vector_load_out && vector_id_out > SRC_TRAP |=> mask == $past(ent_mask))
    else $error("mask not routine level after entry");
  halt_mask_a: assert property (halt_ok |=> ##1 mask == MASK_HALT)
    else $error("mask not forced on halt");
  halt_stop_a: assert property ($rose(halted_out) |-> !osc_run_out && !periph_clk_en_out)
    else $error("clocks running in halt");
  halt_refuse_a: assert property (cpu_cmd_in.halt && timebase_irq_enable_in && !halted_out |=> !halted_out [*2])
    else $error("halt taken with time base enabled");
  wdg_halt_a: assert property (cpu_cmd_in.halt && watchdog_enabled_in && watchdog_in_stop_option_in |-> ##[1:2] wdg_reset_out)
    else $error("no watchdog reset on halt");
  wake_delay_a: assert property (vector_load_out |-> up_cnt >= STARTUP_SHORT_CYC)
    else $error("vector before oscillator start-up delay");
  vec_pulse_a: assert property (vector_load_out |=> !vector_load_out)
    else $error("vector load longer than one cycle");
endmodule
bind ipw_ctrl ipw_checker u_checker (
  .clk_in,
  .sys_rst_in,
  .cpu_cmd_in,
  .software_priority_registers_in,
  .timebase_irq_enable_in,
  .watchdog_enabled_in,
  .watchdog_in_stop_option_in,
  .push_req_out,
  .vector_load_out,
  .vector_id_out,
  .mask_level_high_bit_out,
  .mask_level_low_bit_out,
  .osc_run_out,
  .periph_clk_en_out,
  .halted_out,
  .wdg_reset_out
);

// ### tb/ipw_core_model.sv
// core-side model that answers stacking requests promptly or slowly
`timescale 1ns/100ps
module ipw_core_model (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic push_req_in,
  input wire logic slow_in,
  output logic push_done_out
);
  logic [2:0] wait_r;
  // stacking pc, x, a and cc takes one cycle, or five when slow
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wait_r <= 3'h0;
      push_done_out <= 1'b0;
    end else begin
      push_done_out <= 1'b0;
      if (!push_req_in || push_done_out) begin
        wait_r <= 3'h0;
      end else if (wait_r == (slow_in ? 3'h4 : 3'h0)) begin
        push_done_out <= 1'b1;
      end else begin
        wait_r <= wait_r + 3'h1;
      end
    end
  end
endmodule

// ### tb/testbench.sv
// testbench for the interrupt controller and halt logic
`timescale 1ns/100ps
module testbench;
  import ipw_pkg::*;
  logic clk_in, sys_rst_in, top_level_pin_interrupt, tb_en, wdg_en, wdg_opt, trap, halt, iret, slow, pdone, seen;
  logic tli_rise;
  logic [7:0] ext_pin;
  logic [3:0] pflag, pen, pclr, vid;
  logic push_req, vld, mhi, mlo, osc, pclk, halted, wdg;
  ipw_cpu_cmd_s cmd;
  ipw_ext_cfg_s ecfg;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  assign cmd = {1'b1, trap, halt, iret, pdone};
  ipw_ctrl DUT (
    .clk_in,
    .sys_rst_in,
    .cpu_cmd_in(cmd),
    .top_level_pin_interrupt_in(top_level_pin_interrupt),
    .top_level_pin_rising_in(tli_rise),
    .ext_pin_in(ext_pin),
    .external_irq_sensitivity_control_in(ecfg),
    .software_priority_registers_in(12'he89),
    .periph_flag_in(pflag),
    .periph_enable_in(pen),
    .periph_clear_seq_in(pclr),
    .timebase_irq_enable_in(tb_en),
    .watchdog_enabled_in(wdg_en),
    .watchdog_in_stop_option_in(wdg_opt),
    .startup_long_in(1'b0),
    .push_req_out(push_req),
    .vector_load_out(vld),
    .vector_id_out(vid),
    .mask_level_high_bit_out(mhi),
    .mask_level_low_bit_out(mlo),
    .osc_run_out(osc),
    .periph_clk_en_out(pclk),
    .halted_out(halted),
    .wdg_reset_out(wdg)
  );
  ipw_core_model u_core (
    .clk_in,
    .sys_rst_in,
    .push_req_in(push_req),
    .slow_in(slow),
    .push_done_out(pdone)
  );
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // waits for the vector pulse, then checks the new mask one cycle on
  task automatic take(input logic [3:0] id, input logic [1:0] m);
    int n;
    n = 0;
    while (vld !== 1'b1 && n < 6000) begin
      tick(1);
      n++;
    end
    chk("vector id", {4'h0, id}, {4'h0, vid});
    tick(1);
    chk("mask", {6'h0, m}, {6'h0, mhi, mlo});
  endtask
  task automatic idle(input int n);
    seen = 1'b0;
    repeat (n) begin
      tick(1);
      seen = seen | push_req;
    end
    chk("no entry", 8'h0, {7'h0, seen});
  endtask
  task automatic ret(input logic [1:0] m);
    iret = 1'b1;
    tick(1);
    iret = 1'b0;
    tick(1);
    chk("mask after return", {6'h0, m}, {6'h0, mhi, mlo});
  endtask
  task automatic pclear(input int i);
    pflag[i] = 1'b0;
    pclr[i] = 1'b1;
    tick(1);
    pclr[i] = 1'b0;
  endtask
  task automatic hpulse();
    halt = 1'b1;
    tick(1);
    halt = 1'b0;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // a hang ends the run as a failure
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    sys_rst_in = 1'b1;
    {top_level_pin_interrupt, tb_en, wdg_en, wdg_opt, trap, halt, iret, slow} = 8'h0;
    tli_rise = 1'b1;
    ext_pin = 8'h0;
    pflag = 4'h0;
    pen = 4'hb;
    pclr = 4'h0;
    ecfg = '{pin_sel: 8'h06, sens: 4'h1};
    tick(10);
    chk("reset outputs", 8'h38, {push_req, vld, mhi, mlo, osc, pclk, halted, wdg});
    sys_rst_in = 1'b0;
    take(4'h0, 2'h3);
    pflag = 4'h2;
    idle(20);
    tb_en = 1'b1;
    hpulse();
    tick(2);
    chk("halted", 8'h0, {7'h0, halted});
    tb_en = 1'b0;
    wdg_en = 1'b1;
    wdg_opt = 1'b1;
    hpulse();
    seen = wdg;
    tick(1);
    chk("watchdog reset", 8'h1, {7'h0, seen | wdg});
    chk("halted", 8'h0, {7'h0, halted});
    wdg_en = 1'b0;
    pclear(1);
    hpulse();
    tick(1);
    chk("halt mask", 8'h2, {6'h0, mhi, mlo});
    chk("halt clocks", 8'h1, {5'h0, osc, pclk, halted});
    tick(20);
    chk("still halted", 8'h1, {7'h0, halted});
    ext_pin[2] = 1'b1;
    take(4'h3, 2'h1);
    chk("awake", 8'h2, {6'h0, osc, halted});
    pflag = 4'h4;
    idle(10);
    pflag = 4'he;
    take(4'h8, 2'h3);
    pclear(3);
    pen = 4'hf;
    slow = 1'b1;
    trap = 1'b1;
    tick(1);
    trap = 1'b0;
    take(4'h2, 2'h3);
    top_level_pin_interrupt = 1'b1;
    take(4'h1, 2'h3);
    ret(2'h3);
    ret(2'h3);
    ret(2'h1);
    take(4'h6, 2'h0);
    pclear(1);
    idle(10);
    ret(2'h1);
    take(4'h7, 2'h0);
    pclear(2);
    ret(2'h1);
    ret(2'h2);
    idle(20);
    // switch to falling-edge mode while the pin is steady high, then drop it
    tli_rise = 1'b0;
    top_level_pin_interrupt = 1'b0;
    take(4'h1, 2'h3);
    ret(2'h2);
    summarize();
  end
endmodule
